// ### hw/fsmc_pkg.sv
`default_nettype none
package fsmc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STAT = 8'h00; // status flags, launch
	localparam logic [7:0] OFS_IDX = 8'h04; // parameter slot index
	localparam logic [7:0] OFS_PARAM = 8'h08; // first parameter word
	localparam logic [7:0] OFS_PARAM_END = 8'h1C; // last parameter word
	localparam logic [7:0] OFS_CFG = 8'h20; // key enable, mode, protect
	localparam logic [7:0] OFS_STATE = 8'h24; // security and margins
	// status register bits
	localparam int B_CC = 7; // command complete
	localparam int B_ACC = 5; // access error
	localparam int B_PV = 4; // protection violation
	localparam int B_VE = 1; // verify error
	localparam int B_UE = 0; // uncorrectable error
	// configuration register bits
	localparam int B_BACKDOOR_KEY_ENABLE_FIELD = 0; // two-bit key enable field
	localparam int B_SPECIAL = 2; // special operating mode
	localparam int B_PROT = 3; // some region protected
	// state register bits
	localparam int B_SEC = 0; // secured
	localparam int B_LOCK = 1; // key mismatched since reset
	localparam int B_PFM = 2; // program flash margin, 3 bits
	localparam int B_EEM = 5; // data flash margin, 3 bits
	// reset values
	localparam logic [3:0] CFG_RST = 4'h0;
	localparam logic SEC_RST = 1'b1;
	localparam logic [2:0] MARGIN_NORMAL = 3'h0;
	// command codes
	localparam logic [7:0] CMD_UNSEC = 8'h0B;
	localparam logic [7:0] CMD_KEY = 8'h0C;
	localparam logic [7:0] CMD_UMARG = 8'h0D;
	localparam logic [7:0] CMD_FMARG = 8'h0E;
	// required slot index at launch
	localparam logic [2:0] IDX_UNSEC = 3'h0;
	localparam logic [2:0] IDX_KEY = 3'h4;
	localparam logic [2:0] IDX_MARG = 3'h2;
	localparam logic [1:0] BACKDOOR_KEY_ENABLE_FIELD_ON = 2'h2;
	// highest valid margin settings
	localparam logic [15:0] UMARG_MAX = 16'h0002;
	localparam logic [15:0] FMARG_MAX = 16'h0004;
	// stored key and block map
	localparam logic [23:0] KEY_BASE = 24'hFF_FE00;
	localparam logic [23:0] KEY_STEP = 24'h00_0002;
	localparam logic [1:0] KEY_LAST = 2'h3;
	localparam logic [7:0] EE_BLOCK = 8'h10;
	localparam logic [7:0] PF_BLOCK_LO = 8'hC0;
	localparam logic [1:0] KIND_NONE = 2'h0;
	localparam logic [1:0] KIND_PF = 2'h1;
	localparam logic [1:0] KIND_EE = 2'h2;
	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_CHECK = 4'h2,
		S_ERASE = 4'h4,
		S_KEY = 4'h8
	} fsmc_state_t;
endpackage : fsmc_pkg
`default_nettype wire

// ### hw/fsmc_top.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RQ1] unsecure erases all, verifies, then releases
// [RQ2] failed verify sets verify error, security kept
// [RQ3] unsecure needs slot index 000
// [RQ4] unsecure refused when anything protected
// [RQ5] uncorrectable sets both error flags
// [RQ6] host writes nothing while command runs
// [RQ7] complete flag set after unsecure ends
// [RQ8] key check needs key enable 10
// [RQ9] key command 0x0C, index 100
// [RQ10] keys compared in order from 0xFF_FE00
// [RQ11] mismatch locks key command until reset
// [RQ12] user margin 0x0D, index 010
// [RQ13] user margins 0, 1, 2 accepted
// [RQ14] bad margin value gives access error
// [RQ15] unknown block address gives access error
// [RQ16] program flash margin covers both arrays
// [RQ17] margin stored on the same edge the complete flag is set
// [RQ18] field margin 0x0E only in special mode
// [RQ19] field margin also accepts 3 and 4
// [RQ20] command illegal in mode gives access error
// [RQ21] margin holds until changed or reset
module fsmc_top (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [7:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	output logic ERASE_REQ,
	input wire logic ERASE_DONE,
	input wire logic VERIFY_ERR,
	input wire logic VERIFY_UNCORR,
	output logic [23:0] KEY_ADDR,
	input wire logic [15:0] KEY_DATA,
	output logic SECURED,
	output logic [2:0] PF_MARGIN,
	output logic [2:0] EE_MARGIN
);

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] lane(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0] sel
	);
		lane = old;
		if (sel[0])
		begin
			lane[7:0] = dat[7:0];
		end
		if (sel[1])
		begin
			lane[15:8] = dat[15:8];
		end
	endfunction : lane

	// which array a global address names
	function automatic logic [1:0] blk_kind(input logic [23:0] a);
		if (a[23:16] == fsmc_pkg::EE_BLOCK)
		begin
			blk_kind = fsmc_pkg::KIND_EE;
		end
		else if (a[23:16] >= fsmc_pkg::PF_BLOCK_LO)
		begin
			blk_kind = fsmc_pkg::KIND_PF;
		end
		else
		begin
			blk_kind = fsmc_pkg::KIND_NONE;
		end
	endfunction : blk_kind

	logic [1:0] rst_pipe; // reset release stages
	logic rst_n; // synchronised reset
	logic ack; // bus acknowledge
	logic req; // request waiting for ack
	logic fire; // request completes this edge
	logic wr_ok; // write allowed, no command running
	logic launch; // command start
	logic command_complete_flag; // command complete flag
	logic acc; // access error flag
	logic pv; // protection violation flag
	logic ve; // verify error flag
	logic ue; // uncorrectable error flag
	logic [2:0] idx; // parameter slot index
	logic [15:0] param [0:5]; // command parameter words
	logic [3:0] cfg; // configuration bits
	logic sec; // security engaged
	logic key_lock; // key mismatched since reset
	logic [2:0] pf_m; // program flash margin
	logic [2:0] ee_m; // data flash margin
	logic [23:0] key_addr; // stored key word address
	fsmc_pkg::fsmc_state_t state; // sequencer state
	fsmc_pkg::fsmc_state_t next_state; // following state
	logic [7:0] cmd; // command code
	logic [23:0] gaddr; // global block address
	logic [1:0] kind; // targeted array
	logic [2:0] kslot; // parameter slot of current key
	logic chk_acc; // launch check: access error
	logic chk_pv; // launch check: protection
	logic ev_done; // command finished
	logic ev_release; // security released
	logic ev_ve; // verify error event
	logic ev_ue; // uncorrectable event
	logic ev_miss; // key mismatch event
	logic ev_margin; // store margin event

	// reset release through two stages
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_pipe <= 2'h0;
		end
		else
		begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// bus handshake, one wait state
	assign req = WB_CYC & WB_STB & ~ack;
	assign fire = WB_CYC & WB_STB & ack;
	assign wr_ok = fire & WB_WE & command_complete_flag; // [RQ6]
	assign launch = wr_ok & (WB_ADR == fsmc_pkg::OFS_STAT)
		& WB_SEL[0] & WB_DAT_I[fsmc_pkg::B_CC];
	assign WB_ACK = ack;

	// acknowledge, dropped the cycle after
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
		end
		else
		begin
			ack <= req;
		end
	end

	// read data, unmapped reads as zero
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			WB_DAT_O <= 32'h0000_0000;
		end
		else if (req)
		begin
			WB_DAT_O <= 32'h0000_0000;
			case (WB_ADR)
				fsmc_pkg::OFS_STAT: WB_DAT_O[7:0] <= {command_complete_flag, 1'b0, acc, pv, 2'h0, ve, ue};
				fsmc_pkg::OFS_IDX: WB_DAT_O[2:0] <= idx;
				fsmc_pkg::OFS_CFG: WB_DAT_O[3:0] <= cfg;
				fsmc_pkg::OFS_STATE: WB_DAT_O[7:0] <= {ee_m, pf_m, key_lock, sec};
				default:
				begin
					// parameter words, 4 bytes apart
					if (WB_ADR >= fsmc_pkg::OFS_PARAM && WB_ADR <= fsmc_pkg::OFS_PARAM_END
						&& WB_ADR[1:0] == 2'h0)
					begin
						WB_DAT_O[15:0] <= param[3'(WB_ADR[7:2] - 6'h02)];
					end
				end
			endcase
		end
	end

	// slot index and configuration writes
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idx <= 3'h0;
			cfg <= fsmc_pkg::CFG_RST;
		end
		else if (wr_ok && WB_SEL[0])
		begin
			if (WB_ADR == fsmc_pkg::OFS_IDX)
			begin
				idx <= WB_DAT_I[2:0];
			end
			if (WB_ADR == fsmc_pkg::OFS_CFG)
			begin
				cfg <= WB_DAT_I[3:0];
			end
		end
	end

	// parameter word writes
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 6; i++)
			begin
				param[i] <= 16'h0000;
			end
		end
		else if (wr_ok && WB_ADR >= fsmc_pkg::OFS_PARAM
			&& WB_ADR <= fsmc_pkg::OFS_PARAM_END && WB_ADR[1:0] == 2'h0)
		begin
			param[3'(WB_ADR[7:2] - 6'h02)] <= lane(param[3'(WB_ADR[7:2] - 6'h02)],
				WB_DAT_I, WB_SEL);
		end
	end

	// command fields from the parameter words
	assign cmd = param[0][15:8];
	assign gaddr = {param[0][7:0], param[1]};
	assign kind = blk_kind(gaddr);
	assign kslot = {1'b0, key_addr[2:1]} + 3'h1;

	// launch checks per command
	always_comb
	begin
		chk_acc = 1'b0;
		chk_pv = 1'b0;
		case (cmd)
			fsmc_pkg::CMD_UNSEC:
			begin
				chk_acc = (idx != fsmc_pkg::IDX_UNSEC); // [RQ3]
				chk_pv = cfg[fsmc_pkg::B_PROT]; // [RQ4]
			end
			fsmc_pkg::CMD_KEY:
			begin
				chk_acc = (idx != fsmc_pkg::IDX_KEY) // [RQ9]
					| (cfg[fsmc_pkg::B_BACKDOOR_KEY_ENABLE_FIELD +: 2] != fsmc_pkg::BACKDOOR_KEY_ENABLE_FIELD_ON) // [RQ8]
					| key_lock; // [RQ11]
			end
			fsmc_pkg::CMD_UMARG:
			begin
				chk_acc = (idx != fsmc_pkg::IDX_MARG) // [RQ12]
					| (kind == fsmc_pkg::KIND_NONE) // [RQ15]
					| (param[2] > fsmc_pkg::UMARG_MAX); // [RQ13] [RQ14]
			end
			fsmc_pkg::CMD_FMARG:
			begin
				chk_acc = (idx != fsmc_pkg::IDX_MARG)
					| (kind == fsmc_pkg::KIND_NONE)
					| (param[2] > fsmc_pkg::FMARG_MAX) // [RQ19]
					| ~cfg[fsmc_pkg::B_SPECIAL]; // [RQ18] [RQ20]
			end
			default: chk_acc = 1'b1; // not a command of this block
		endcase
	end

	// sequencer next state and events
	always_comb
	begin
		next_state = state;
		ev_done = 1'b0;
		ev_release = 1'b0;
		ev_ve = 1'b0;
		ev_ue = 1'b0;
		ev_miss = 1'b0;
		ev_margin = 1'b0;
		case (state)
			fsmc_pkg::S_IDLE:
			begin
				if (launch)
				begin
					next_state = fsmc_pkg::S_CHECK;
				end
			end
			fsmc_pkg::S_CHECK:
			begin
				if (chk_acc || chk_pv)
				begin
					// refused, complete at once
					ev_done = 1'b1;
					next_state = fsmc_pkg::S_IDLE;
				end
				else if (cmd == fsmc_pkg::CMD_UNSEC)
				begin
					next_state = fsmc_pkg::S_ERASE; // [RQ1]
				end
				else if (cmd == fsmc_pkg::CMD_KEY)
				begin
					next_state = fsmc_pkg::S_KEY;
				end
				else
				begin
					ev_margin = 1'b1; // [RQ17]
					ev_done = 1'b1;
					next_state = fsmc_pkg::S_IDLE;
				end
			end
			fsmc_pkg::S_ERASE:
			begin
				if (ERASE_DONE)
				begin
					ev_ve = VERIFY_ERR | VERIFY_UNCORR; // [RQ2] [RQ5]
					ev_ue = VERIFY_UNCORR; // [RQ5]
					ev_release = ~(VERIFY_ERR | VERIFY_UNCORR); // [RQ1]
					ev_done = 1'b1; // [RQ7]
					next_state = fsmc_pkg::S_IDLE;
				end
			end
			fsmc_pkg::S_KEY:
			begin
				if (KEY_DATA != param[kslot])
				begin
					ev_miss = 1'b1; // [RQ11]
					ev_done = 1'b1;
					next_state = fsmc_pkg::S_IDLE;
				end
				else if (key_addr[2:1] == fsmc_pkg::KEY_LAST)
				begin
					ev_release = 1'b1; // [RQ10]
					ev_done = 1'b1;
					next_state = fsmc_pkg::S_IDLE;
				end
			end
			default: next_state = fsmc_pkg::S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= fsmc_pkg::S_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end
	assign ERASE_REQ = (state == fsmc_pkg::S_ERASE);

	// stored key walk, one word per cycle
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_addr <= fsmc_pkg::KEY_BASE;
		end
		else if (state == fsmc_pkg::S_CHECK)
		begin
			key_addr <= fsmc_pkg::KEY_BASE; // [RQ10]
		end
		else if (state == fsmc_pkg::S_KEY && KEY_DATA == param[kslot])
		begin
			key_addr <= key_addr + fsmc_pkg::KEY_STEP;
		end
	end
	assign KEY_ADDR = key_addr;

	// complete flag, cleared by launch
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			command_complete_flag <= 1'b1;
		end
		else if (ev_done)
		begin
			command_complete_flag <= 1'b1;
		end
		else if (launch)
		begin
			command_complete_flag <= 1'b0;
		end
	end

	// error flags: acc and pv write one to clear, ve and ue cleared by launch, set wins
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc <= 1'b0;
			pv <= 1'b0;
			ve <= 1'b0;
			ue <= 1'b0;
		end
		else
		begin
			if ((state == fsmc_pkg::S_CHECK && chk_acc) || ev_miss)
			begin
				acc <= 1'b1;
			end
			else if (wr_ok && WB_ADR == fsmc_pkg::OFS_STAT && WB_SEL[0] && WB_DAT_I[fsmc_pkg::B_ACC])
			begin
				acc <= 1'b0;
			end
			if (state == fsmc_pkg::S_CHECK && chk_pv)
			begin
				pv <= 1'b1;
			end
			else if (wr_ok && WB_ADR == fsmc_pkg::OFS_STAT && WB_SEL[0] && WB_DAT_I[fsmc_pkg::B_PV])
			begin
				pv <= 1'b0;
			end
			if (ev_ve)
			begin
				ve <= 1'b1;
			end
			else if (launch)
			begin
				ve <= 1'b0; // verify result is per command
			end
			if (ev_ue)
			begin
				ue <= 1'b1;
			end
			else if (launch)
			begin
				ue <= 1'b0;
			end
		end
	end

	// security state and key lock
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec <= fsmc_pkg::SEC_RST;
			key_lock <= 1'b0;
		end
		else
		begin
			if (ev_release)
			begin
				sec <= 1'b0;
			end
			if (ev_miss)
			begin
				key_lock <= 1'b1; // [RQ11]
			end
		end
	end
	assign SECURED = sec;

	// read margins per array
	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pf_m <= fsmc_pkg::MARGIN_NORMAL; // [RQ21]
			ee_m <= fsmc_pkg::MARGIN_NORMAL;
		end
		else if (ev_margin)
		begin
			ee_m <= param[2][2:0]; // [RQ16]
			if (kind == fsmc_pkg::KIND_PF)
			begin
				pf_m <= param[2][2:0];
			end
		end
	end
	assign PF_MARGIN = pf_m;
	assign EE_MARGIN = ee_m;

	// checks on the sequencer
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!rst_n);

	property p_unsec_idx;
		state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_UNSEC
			&& idx != fsmc_pkg::IDX_UNSEC |=> acc && command_complete_flag && state == fsmc_pkg::S_IDLE;
	endproperty
	a_unsec_idx: assert property (p_unsec_idx) else $error("unsecure index not refused"); // [RQ3]

	property p_unsec_prot;
		state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_UNSEC
			&& cfg[fsmc_pkg::B_PROT] |=> pv && !ERASE_REQ;
	endproperty
	a_unsec_prot: assert property (p_unsec_prot) else $error("protected erase ran"); // [RQ4]

	property p_release;
		ERASE_REQ && ERASE_DONE && !VERIFY_ERR && !VERIFY_UNCORR |=> !SECURED && command_complete_flag;
	endproperty
	a_release: assert property (p_release) else $error("security not released"); // [RQ1]

	property p_verify_fail;
		ERASE_REQ && ERASE_DONE && VERIFY_ERR |=> ve && SECURED == $past(SECURED);
	endproperty
	a_verify_fail: assert property (p_verify_fail) else $error("failed verify mishandled"); // [RQ2]

	property p_uncorr;
		ERASE_REQ && ERASE_DONE && VERIFY_UNCORR |=> ue && ve;
	endproperty
	a_uncorr: assert property (p_uncorr) else $error("uncorrectable flags wrong"); // [RQ5]

	property p_backdoor_key_enable_field;
		state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_KEY
			&& cfg[1:0] != fsmc_pkg::BACKDOOR_KEY_ENABLE_FIELD_ON |=> acc && state == fsmc_pkg::S_IDLE;
	endproperty
	a_backdoor_key_enable_field: assert property (p_backdoor_key_enable_field) else $error("disabled key check ran"); // [RQ8]

	property p_lock;
		key_lock && state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_KEY
			|=> acc ##1 SECURED == $past(SECURED, 2);
	endproperty
	a_lock: assert property (p_lock) else $error("locked key check ran"); // [RQ11]

	property p_field_mode;
		state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_FMARG && !cfg[fsmc_pkg::B_SPECIAL]
			|=> acc && $stable(pf_m) && $stable(ee_m);
	endproperty
	a_field_mode: assert property (p_field_mode) else $error("field margin outside special"); // [RQ20]

	property p_bad_margin;
		state == fsmc_pkg::S_CHECK && cmd == fsmc_pkg::CMD_UMARG
			&& param[2] > fsmc_pkg::UMARG_MAX |=> acc && $stable(ee_m);
	endproperty
	a_bad_margin: assert property (p_bad_margin) else $error("bad margin accepted"); // [RQ14]

	// complete stays low until the erase engine reports done
	property p_busy;
		ERASE_REQ && !ERASE_DONE |=> !command_complete_flag;
	endproperty
	a_busy: assert property (p_busy) else $error("complete flag early"); // [RQ7]

	c_unsec: cover property (ERASE_REQ && ERASE_DONE && !VERIFY_ERR);
	c_key_ok: cover property (state == fsmc_pkg::S_KEY && ev_release);
	c_margin: cover property (ev_margin && kind == fsmc_pkg::KIND_PF);

endmodule : fsmc_top
`default_nettype wire

// ### dv/fsmc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// compare two values, count it, report a mismatch
`define CHK(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module fsmc_top_tb;
	logic mclk; // bench clock
	logic arst_n; // async reset
	logic cyc, stb, we; // bus request
	logic [3:0] sel; // byte lanes
	logic [7:0] adr; // byte address
	logic [31:0] wdat; // write data
	logic [31:0] rdat; // read data
	logic ack; // bus answer
	logic erase_req, erase_done, ver_err, ver_unc; // erase engine
	logic [23:0] key_addr; // stored key address
	logic [15:0] key_data; // stored key word
	logic secured; // security engaged
	logic [2:0] pf_m, ee_m; // read margins
	logic [3:0] ecnt; // erase duration count
	logic erase_seen; // erase was requested
	int err_total; // mismatches
	int cmp_count; // comparisons
	fsmc_top fsmc_top_inst (.MCLK(mclk), .ARST_N(arst_n), .WB_CYC(cyc), .WB_STB(stb),
		.WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK(ack), .ERASE_REQ(erase_req), .ERASE_DONE(erase_done),
		.VERIFY_ERR(ver_err), .VERIFY_UNCORR(ver_unc), .KEY_ADDR(key_addr),
		.KEY_DATA(key_data), .SECURED(secured), .PF_MARGIN(pf_m), .EE_MARGIN(ee_m));
	// stored key, a different word at every address
	assign key_data = 16'hA5C0 + key_addr[15:0];
	// clock generator
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// erase engine: done pulse four cycles into a request
	always @(posedge mclk)
	begin
		erase_done <= 1'b0;
		if (erase_req === 1'b1 && erase_done !== 1'b1)
		begin
			erase_seen <= 1'b1;
			ecnt <= ecnt + 4'h1;
			if (ecnt == 4'h3)
				erase_done <= 1'b1;
		end
		else
			ecnt <= 4'h0;
	end
	// expected stored key word k
	function automatic logic [15:0] key_of(input int k);
		return 16'hA5C0 + 16'hFE00 + 16'(2 * k);
	endfunction : key_of
	// verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// hold reset for 20 cycles
	task automatic do_reset;
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : do_reset
	// one classic single cycle, held until ack
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wdat <= d;
		// ack is looked at on rising edges only; the watchdog ends a hang
		do
		begin
			@(posedge mclk);
		end
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
	endtask : wb_cycle
	// register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb_cycle(1'b1, a, d, r);
	endtask : wr
	// register read
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		wb_cycle(1'b0, a, 32'h0, r);
	endtask : rd
	// load parameters, launch, wait for complete
	task automatic run_cmd(input logic [2:0] idx, input logic [15:0] w0, w1, w2, w3, w4);
		logic [31:0] r;
		int n;
		wr(8'h00, 32'h30);
		wr(8'h08, {16'h0, w0});
		wr(8'h0C, {16'h0, w1});
		wr(8'h10, {16'h0, w2});
		wr(8'h14, {16'h0, w3});
		wr(8'h18, {16'h0, w4});
		wr(8'h04, {29'h0, idx});
		erase_seen <= 1'b0;
		wr(8'h00, 32'h80);
		n = 0;
		do
		begin
			rd(8'h00, r);
			n++;
		end
		while (r[7] !== 1'b1 && n < 100);
		`CHK("complete", 1'b1, r[7])
	endtask : run_cmd
	// status and state registers against expectations
	task automatic chk(input string nm, input logic [7:0] st, input logic [7:0] sv);
		logic [31:0] r;
		rd(8'h00, r);
		`CHK({nm, " status"}, {24'h0, st}, r)
		rd(8'h24, r);
		`CHK({nm, " state"}, {24'h0, sv}, r)
	endtask : chk
	// margin command on one block
	task automatic marg(input logic [7:0] cmd, input logic [2:0] idx, input logic [7:0] blk,
		input logic [15:0] m);
		run_cmd(idx, {cmd, blk}, 16'h0000, m, 16'h0, 16'h0);
	endtask : marg
	// key command with key 3 optionally spoiled
	task automatic key(input logic [2:0] idx, input logic [15:0] spoil);
		run_cmd(idx, 16'h0C00, key_of(0), key_of(1), key_of(2), key_of(3) ^ spoil);
	endtask : key
	// values after reset, unmapped read
	task automatic t_reset;
		logic [31:0] r;
		chk("reset", 8'h80, 8'h01);
		`CHK("key addr", 24'hFF_FE00, key_addr)
		rd(8'h40, r);
		`CHK("unmapped", 32'h0, r)
		$display("test reset done");
	endtask : t_reset
	// user margin values, targets and refusals
	task automatic t_umarg;
		for (int m = 0; m < 3; m++)
		begin
			marg(8'h0D, 3'h2, 8'hC0, 16'(m));
			chk("umarg pf", 8'h80, {3'(m), 3'(m), 2'b01});
		end
		marg(8'h0D, 3'h2, 8'h10, 16'h0001);
		chk("umarg ee", 8'h80, {3'h1, 3'h2, 2'b01});
		marg(8'h0D, 3'h2, 8'hC0, 16'h0003);
		chk("umarg value", 8'hA0, {3'h1, 3'h2, 2'b01});
		marg(8'h0D, 3'h2, 8'h50, 16'h0000);
		chk("umarg block", 8'hA0, {3'h1, 3'h2, 2'b01});
		marg(8'h0D, 3'h3, 8'hC0, 16'h0000);
		chk("umarg index", 8'hA0, {3'h1, 3'h2, 2'b01});
		`CHK("pf pin", 3'h2, pf_m)
		`CHK("ee pin", 3'h1, ee_m)
		$display("test user margin done");
	endtask : t_umarg
	// field margin needs special mode, accepts 3 and 4
	task automatic t_fmarg;
		marg(8'h0E, 3'h2, 8'hC0, 16'h0003);
		chk("fmarg mode", 8'hA0, {3'h1, 3'h2, 2'b01});
		wr(8'h20, 32'h04);
		marg(8'h0E, 3'h2, 8'hC0, 16'h0003);
		chk("fmarg pf", 8'h80, {3'h3, 3'h3, 2'b01});
		marg(8'h0E, 3'h2, 8'h10, 16'h0004);
		chk("fmarg ee", 8'h80, {3'h4, 3'h3, 2'b01});
		marg(8'h0E, 3'h2, 8'h10, 16'h0005);
		chk("fmarg value", 8'hA0, {3'h4, 3'h3, 2'b01});
		marg(8'h0E, 3'h2, 8'hC0, 16'h0000);
		chk("fmarg normal", 8'h80, 8'h01);
		marg(8'h0E, 3'h2, 8'hC0, 16'h0002);
		chk("fmarg user", 8'h80, {3'h2, 3'h2, 2'b01});
		wr(8'h20, 32'h00);
		$display("test field margin done");
	endtask : t_fmarg
	// key command refusals and a match
	task automatic t_key_ok;
		wr(8'h20, 32'h02);
		key(3'h3, 16'h0);
		chk("key index", 8'hA0, 8'h01);
		wr(8'h20, 32'h00);
		key(3'h4, 16'h0);
		chk("key enable", 8'hA0, 8'h01);
		wr(8'h20, 32'h02);
		key(3'h4, 16'h0);
		chk("key match", 8'h80, 8'h00);
		`CHK("secured pin", 1'b0, secured)
		$display("test key match done");
	endtask : t_key_ok
	// mismatch locks later attempts
	task automatic t_key_bad;
		wr(8'h20, 32'h02);
		key(3'h4, 16'h0001);
		chk("key mismatch", 8'hA0, 8'h03);
		key(3'h4, 16'h0);
		chk("key locked", 8'hA0, 8'h03);
		`CHK("secured pin", 1'b1, secured)
		$display("test key lock done");
	endtask : t_key_bad
	// unsecure refusals, verify failures, success
	task automatic t_unsec;
		wr(8'h20, 32'h00);
		run_cmd(3'h1, 16'h0B00, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("unsec index", 8'hA0, 8'h03);
		`CHK("no erase", 1'b0, erase_seen)
		wr(8'h20, 32'h08);
		run_cmd(3'h0, 16'h0B00, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("unsec protect", 8'h90, 8'h03);
		`CHK("no erase", 1'b0, erase_seen)
		wr(8'h20, 32'h00);
		ver_err <= 1'b1;
		run_cmd(3'h0, 16'h0B00, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("unsec verify", 8'h82, 8'h03);
		`CHK("erase", 1'b1, erase_seen)
		ver_err <= 1'b0;
		ver_unc <= 1'b1;
		run_cmd(3'h0, 16'h0B00, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("unsec uncorr", 8'h83, 8'h03);
		ver_unc <= 1'b0;
		run_cmd(3'h0, 16'h0B00, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("unsec pass", 8'h80, 8'h02);
		`CHK("erase end", 1'b0, erase_req)
		$display("test unsecure done");
	endtask : t_unsec
	// watchdog against a hang
	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		$display("CHECK FAILED watchdog expected end seen timeout");
		test_done();
	end
	// main sequence
	initial
	begin
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = 8'h00;
		wdat = 32'h0;
		erase_done = 1'b0;
		ver_err = 1'b0;
		ver_unc = 1'b0;
		ecnt = 4'h0;
		erase_seen = 1'b0;
		err_total = 0;
		cmp_count = 0;
		do_reset();
		t_reset();
		t_umarg();
		t_fmarg();
		do_reset();
		t_reset();
		t_key_ok();
		do_reset();
		t_key_bad();
		t_unsec();
		test_done();
	end
endmodule : fsmc_top_tb
`default_nettype wire
